// ### include/dam_pkg.sv
// Purpose: Shared constants and types for the data map and address mode block
// Assumes: 8-bit data space, 15-bit program counter
// Notes: Addresses are byte addresses in the 8-bit data space
package dam_pkg;
  // ****************************************
  // Data map
  // ****************************************
  localparam logic [7:0] RAM_TOP_SMALL = 8'h2F;
  localparam logic [7:0] RAM_TOP_LARGE = 8'h6F;
  localparam logic [7:0] ONES_TOP = 8'h7F;
  localparam logic [7:0] EXP_LO = 8'h80;
  localparam logic [7:0] EXP_HI = 8'hBF;
  localparam logic [7:0] REG_LO = 8'hF0;
  localparam int RAM_SMALL_BYTES = 48;
  localparam int RAM_LARGE_BYTES = 112;
  localparam int REG_BYTES = 16;
  localparam int RAM_DEPTH = RAM_LARGE_BYTES + REG_BYTES;
  localparam logic [7:0] ADDR_WAKE_EDGE = 8'hC8;
  localparam logic [7:0] ADDR_WAKE_EN = 8'hC9;
  localparam logic [7:0] ADDR_WAKE_PEND = 8'hCA;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'hCC;
  localparam logic [7:0] ADDR_WDOG_ARM = 8'hCD;
  localparam logic [7:0] ADDR_WDOG_CNT = 8'hCE;
  localparam logic [7:0] ADDR_MOD_RELOAD = 8'hCF;
  localparam logic [7:0] ADDR_PA_DATA = 8'hD0;
  localparam logic [7:0] ADDR_PA_CFG = 8'hD1;
  localparam logic [7:0] ADDR_PA_PINS = 8'hD2;
  localparam logic [7:0] ADDR_PB_DATA = 8'hD4;
  localparam logic [7:0] ADDR_PB_CFG = 8'hD5;
  localparam logic [7:0] ADDR_PB_PINS = 8'hD6;
  localparam logic [7:0] ADDR_PC_PINS = 8'hD7;
  localparam logic [7:0] ADDR_PD_DATA = 8'hDC;
  localparam logic [7:0] ADDR_SHIFT = 8'hE9;
  localparam logic [7:0] ADDR_TCNT_LO = 8'hEA;
  localparam logic [7:0] ADDR_TCNT_HI = 8'hEB;
  localparam logic [7:0] ADDR_TRLD_LO = 8'hEC;
  localparam logic [7:0] ADDR_TRLD_HI = 8'hED;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'hEE;
  localparam logic [7:0] ADDR_STATUS = 8'hEF;
  localparam logic [7:0] ADDR_SECOND_PTR = 8'hFC;
  localparam logic [7:0] ADDR_STACK_PTR = 8'hFD;
  localparam logic [7:0] ADDR_FIRST_PTR = 8'hFE;
  localparam logic [7:0] ONES_DATA = 8'hFF;
  localparam logic [7:0] UNDEF_DATA = 8'h00;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic WD_ARM_RESET = 1'b0;
  localparam int WD_ARM_BIT = 0;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    M_IND = 3'h0, M_IND_POST = 3'h1, M_DIRECT = 3'h2,
    M_IMM = 3'h3, M_SHORT = 3'h4, M_PROG = 3'h5
  } dam_mode_t;
  typedef enum logic [1:0] {P_NONE = 2'h0, P_INC = 2'h1, P_DEC = 2'h2} dam_post_t;
  typedef enum logic [2:0] {
    R_RAM = 3'h0, R_ONES = 3'h1, R_UNDEF = 3'h2, R_PERIPH = 3'h3,
    R_WDOG = 3'h4, R_IMM = 3'h5, R_PROG = 3'h6
  } dam_region_t;
  typedef enum logic [2:0] {
    F_INC = 3'h0, F_REL = 3'h1, F_ABS = 3'h2, F_LONG = 3'h3, F_IND = 3'h4
  } dam_kind_t;
  typedef enum logic {JS_IDLE = 1'b0, JS_FETCH = 1'b1} dam_jstate_t;
  typedef struct packed {
    logic valid;
    logic write;
    dam_mode_t mode;
    logic ptr_sel;
    dam_post_t post;
    logic [7:0] addr;
    logic [7:0] imm;
    logic [7:0] acc;
    logic [7:0] wdata;
  } dam_req_t;
  typedef struct packed {
    logic valid;
    dam_kind_t kind;
    logic [6:0] offset;
    logic [14:0] target;
    logic [7:0] acc;
  } dam_flow_t;
  typedef struct packed {
    logic valid;
    dam_region_t region;
    logic [7:0] data;
  } dam_rd_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dam_per_t;
endpackage : dam_pkg

// ### hw/dam_core.sv
// Purpose: Data memory decode, operand and next-instruction address forming
// Assumes: Execution unit issues at most one access and one flow request per cycle
// Notes: Every access answers two cycles later on o_rd, except a program load refused for an indirect jump
//
// Overview of operation
// - All RAM, ports and registers live in data space except accumulator and PC.
// - Small variant: 00 to 2F select 48 bytes of RAM.
// - Large variant: 00 to 6F select 112 bytes of RAM.
// - Unimplemented RAM region up to 7F reads all ones.
// - Expansion 80 to BF and other unassigned places read undefined.
// - Wake-up edge, enable, pending decoded at C8, C9, CA.
// - Control two CC, watchdog arm CD, watchdog count CE, modulator reload CF.
// - First port data D0, configuration D1, read-only pins D2.
// - Second port D4, D5, D6; third port pins D7; fourth port data DC.
// - Shift E9, timer count EA/EB, reload EC/ED, control one EE, status EF.
// - F0 to FF are RAM registers; FC second, FD stack, FE first pointer.
// - Register indirect takes address from the selected 8-bit pointer.
// - Pointer optionally post incremented or decremented after the access.
// - Direct mode uses the 8-bit address field of the instruction.
// - Immediate mode operand is the 8-bit constant of the instruction.
// - Load first pointer immediate uses a 4-bit field below 16.
// - Program memory load reads at accumulator as low 8 address bits.
// - Relative jump adds a 7-bit signed offset, -64 to +63, over all 15 PC bits; +1 acts as NOP.
// - Absolute jump and call replace only low 12 PC bits.
// - Long jump and call replace all 15 PC bits.
// - Indirect jump loads fetched program byte into low 8 PC bits.
// - Accumulator, pointers, stack pointer 8 bits; PC 15 bits split 7 and 8.
// - Watchdog arm bit 0 takes one write after reset only.
module dam_core (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_large_mem,
  input wire dam_pkg::dam_req_t i_req,
  input wire dam_pkg::dam_flow_t i_flow,
  input wire logic [7:0] i_per_rdata,
  input wire logic [7:0] i_prog_data,
  output dam_pkg::dam_rd_t o_rd,
  output dam_pkg::dam_per_t o_per,
  output logic o_prog_rd,
  output logic [14:0] o_prog_addr,
  output logic [14:0] o_pc,
  output logic o_flow_busy,
  output logic o_wdog_arm
);
  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic f_is_per(input logic [7:0] a);
    case (a)
      dam_pkg::ADDR_WAKE_EDGE, dam_pkg::ADDR_WAKE_EN,
      dam_pkg::ADDR_WAKE_PEND, dam_pkg::ADDR_CTRL_TWO,
      dam_pkg::ADDR_WDOG_CNT, dam_pkg::ADDR_MOD_RELOAD,
      dam_pkg::ADDR_PA_DATA, dam_pkg::ADDR_PA_CFG,
      dam_pkg::ADDR_PA_PINS, dam_pkg::ADDR_PB_DATA,
      dam_pkg::ADDR_PB_CFG, dam_pkg::ADDR_PB_PINS,
      dam_pkg::ADDR_PC_PINS, dam_pkg::ADDR_PD_DATA,
      dam_pkg::ADDR_SHIFT, dam_pkg::ADDR_TCNT_LO,
      dam_pkg::ADDR_TCNT_HI, dam_pkg::ADDR_TRLD_LO,
      dam_pkg::ADDR_TRLD_HI, dam_pkg::ADDR_CTRL_ONE,
      dam_pkg::ADDR_STATUS: f_is_per = 1'b1;
      default: f_is_per = 1'b0;
    endcase
  endfunction : f_is_per

  function automatic logic f_is_ro(input logic [7:0] a);
    f_is_ro = (a == dam_pkg::ADDR_PA_PINS) || (a == dam_pkg::ADDR_PB_PINS) ||
              (a == dam_pkg::ADDR_PC_PINS);
  endfunction : f_is_ro

  function automatic dam_pkg::dam_region_t f_region(input logic [7:0] a,
                                                    input logic lg);
    logic [7:0] top;
    top = lg ? dam_pkg::RAM_TOP_LARGE : dam_pkg::RAM_TOP_SMALL;
    if (a <= top) begin
      f_region = dam_pkg::R_RAM;
    end else if (a <= dam_pkg::ONES_TOP) begin
      f_region = dam_pkg::R_ONES;
    end else if (a >= dam_pkg::REG_LO) begin
      f_region = dam_pkg::R_RAM;
    end else if (a == dam_pkg::ADDR_WDOG_ARM) begin
      f_region = dam_pkg::R_WDOG;
    end else if (f_is_per(a)) begin
      f_region = dam_pkg::R_PERIPH;
    end else begin
      f_region = dam_pkg::R_UNDEF;
    end
  endfunction : f_region

  // Low RAM and the register file share one array; F0-FF sit above the large RAM
  function automatic logic [6:0] f_idx(input logic [7:0] a);
    f_idx = a[7] ? {3'b111, a[3:0]} : a[6:0];
  endfunction : f_idx

  // ****************************************
  // Operand address forming
  // ****************************************
  logic [7:0] ram_mem [dam_pkg::RAM_DEPTH];
  dam_pkg::dam_jstate_t js_ff;
  logic [14:0] pc_ff;
  logic wd_arm_ff;
  logic wd_lock_ff;
  logic [7:0] ptr_addr;
  logic [7:0] ptr_val;
  logic [7:0] eff_addr;
  logic [6:0] eff_idx;
  dam_pkg::dam_region_t region;
  logic flow_ok;
  logic req_ok;
  logic wr_en;
  logic [7:0] wr_data;
  logic post_en;
  logic [7:0] ptr_next;

  assign flow_ok = i_flow.valid && (js_ff == dam_pkg::JS_IDLE);
  // Program port goes to the indirect jump when both want it
  assign req_ok = i_req.valid &&
                  !(i_req.mode == dam_pkg::M_PROG && flow_ok &&
                    i_flow.kind == dam_pkg::F_IND);
  assign ptr_addr = i_req.ptr_sel ? dam_pkg::ADDR_SECOND_PTR : dam_pkg::ADDR_FIRST_PTR;
  assign ptr_val = ram_mem[f_idx(ptr_addr)];

  always_comb begin
    case (i_req.mode)
      dam_pkg::M_IND, dam_pkg::M_IND_POST: eff_addr = ptr_val;
      dam_pkg::M_DIRECT: eff_addr = i_req.addr;
      dam_pkg::M_SHORT: eff_addr = dam_pkg::ADDR_FIRST_PTR;
      default: eff_addr = i_req.addr;
    endcase
  end

  always_comb begin
    case (i_req.mode)
      dam_pkg::M_IMM: region = dam_pkg::R_IMM;
      dam_pkg::M_PROG: region = dam_pkg::R_PROG;
      dam_pkg::M_SHORT: region = dam_pkg::R_RAM;
      default: region = f_region(eff_addr, i_large_mem);
    endcase
  end

  assign eff_idx = f_idx(eff_addr);
  assign wr_en = req_ok && (i_req.write || i_req.mode == dam_pkg::M_SHORT);
  assign wr_data = (i_req.mode == dam_pkg::M_SHORT) ?
                   {4'h0, i_req.imm[3:0]} : i_req.wdata;
  assign post_en = req_ok && (i_req.mode == dam_pkg::M_IND_POST) &&
                   (i_req.post != dam_pkg::P_NONE);
  assign ptr_next = (i_req.post == dam_pkg::P_INC) ? 8'(ptr_val + 8'h01) :
                    8'(ptr_val - 8'h01);

  // ****************************************
  // RAM and register file
  // ****************************************
  // Pointer update is written last so it wins over a store to the pointer itself
  always_ff @(posedge i_mclk) begin
    if (wr_en && region == dam_pkg::R_RAM) begin
      ram_mem[eff_idx] <= wr_data;
    end
    if (post_en) begin
      ram_mem[f_idx(ptr_addr)] <= ptr_next;
    end
  end

  // ****************************************
  // Watchdog arm register
  // ****************************************
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wd_arm_ff <= dam_pkg::WD_ARM_RESET;
      wd_lock_ff <= 1'b0;
    end else if (wr_en && region == dam_pkg::R_WDOG && !wd_lock_ff) begin
      wd_arm_ff <= i_req.wdata[dam_pkg::WD_ARM_BIT];
      wd_lock_ff <= 1'b1;
    end
  end

  // ****************************************
  // Access pipeline
  // ****************************************
  logic s1_vld_ff;
  dam_pkg::dam_region_t s1_reg_ff;
  logic [7:0] s1_dat_ff;
  logic [7:0] nxt_s1_dat;
  dam_pkg::dam_rd_t rd_ff;
  dam_pkg::dam_per_t per_ff;
  logic prog_rd_ff;
  logic [14:0] prog_addr_ff;

  always_comb begin
    case (region)
      dam_pkg::R_RAM: nxt_s1_dat = ram_mem[eff_idx];
      dam_pkg::R_ONES: nxt_s1_dat = dam_pkg::ONES_DATA;
      dam_pkg::R_WDOG: nxt_s1_dat = {7'h00, wd_arm_ff};
      dam_pkg::R_IMM: nxt_s1_dat = i_req.imm;
      default: nxt_s1_dat = dam_pkg::UNDEF_DATA;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s1_vld_ff <= 1'b0;
      s1_reg_ff <= dam_pkg::R_UNDEF;
      s1_dat_ff <= 8'h00;
    end else begin
      s1_vld_ff <= req_ok;
      s1_reg_ff <= region;
      s1_dat_ff <= nxt_s1_dat;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rd_ff <= '0;
    end else begin
      rd_ff.valid <= s1_vld_ff;
      rd_ff.region <= s1_reg_ff;
      case (s1_reg_ff)
        dam_pkg::R_PERIPH: rd_ff.data <= i_per_rdata;
        dam_pkg::R_PROG: rd_ff.data <= i_prog_data;
        default: rd_ff.data <= s1_dat_ff;
      endcase
    end
  end

  // Read-only pin views never see a write strobe
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      per_ff <= '0;
    end else begin
      per_ff.rd <= req_ok && region == dam_pkg::R_PERIPH;
      per_ff.wr <= wr_en && region == dam_pkg::R_PERIPH && !f_is_ro(eff_addr);
      per_ff.addr <= eff_addr;
      per_ff.wdata <= i_req.wdata;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      prog_rd_ff <= 1'b0;
      prog_addr_ff <= dam_pkg::PC_RESET;
    end else if (flow_ok && i_flow.kind == dam_pkg::F_IND) begin
      prog_rd_ff <= 1'b1;
      prog_addr_ff <= {pc_ff[14:8], i_flow.acc};
    end else if (req_ok && i_req.mode == dam_pkg::M_PROG) begin
      prog_rd_ff <= 1'b1;
      prog_addr_ff <= {pc_ff[14:8], i_req.acc};
    end else begin
      prog_rd_ff <= 1'b0;
    end
  end

  // ****************************************
  // Next instruction address
  // ****************************************
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      js_ff <= dam_pkg::JS_IDLE;
      pc_ff <= dam_pkg::PC_RESET;
    end else begin
      case (js_ff)
        dam_pkg::JS_IDLE: begin
          if (flow_ok) begin
            case (i_flow.kind)
              dam_pkg::F_INC: pc_ff <= 15'(pc_ff + 15'h0001);
              dam_pkg::F_REL: pc_ff <= 15'(pc_ff + 15'($signed(i_flow.offset)));
              dam_pkg::F_ABS: pc_ff <= {pc_ff[14:12], i_flow.target[11:0]};
              dam_pkg::F_LONG: pc_ff <= i_flow.target;
              dam_pkg::F_IND: js_ff <= dam_pkg::JS_FETCH;
              default: pc_ff <= pc_ff;
            endcase
          end
        end
        dam_pkg::JS_FETCH: begin
          pc_ff <= {pc_ff[14:8], i_prog_data};
          js_ff <= dam_pkg::JS_IDLE;
        end
        default: js_ff <= dam_pkg::JS_IDLE;
      endcase
    end
  end

  assign o_rd = rd_ff;
  assign o_per = per_ff;
  assign o_prog_rd = prog_rd_ff;
  assign o_prog_addr = prog_addr_ff;
  assign o_pc = pc_ff;
  assign o_flow_busy = (js_ff == dam_pkg::JS_FETCH);
  assign o_wdog_arm = wd_arm_ff;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  property p_ones;
    o_rd.valid && o_rd.region == dam_pkg::R_ONES |-> o_rd.data == 8'hFF;
  endproperty
  a_ones: assert property (p_ones) else $error("unused RAM not all ones");

  property p_latency;
    req_ok |-> ##2 o_rd.valid;
  endproperty
  a_latency: assert property (p_latency) else $error("read answer late");

  property p_small_ram;
    req_ok && !i_large_mem && i_req.mode == dam_pkg::M_DIRECT &&
    i_req.addr == 8'h30 |-> ##2 o_rd.data == 8'hFF;
  endproperty
  a_small_ram: assert property (p_small_ram) else $error("small RAM top wrong");

  property p_wd_once;
    wd_lock_ff |=> $stable(o_wdog_arm) && wd_lock_ff;
  endproperty
  a_wd_once: assert property (p_wd_once) else $error("watchdog arm rewritten");

  property p_abs;
    flow_ok && i_flow.kind == dam_pkg::F_ABS |=>
      o_pc == {$past(o_pc[14:12]), $past(i_flow.target[11:0])};
  endproperty
  a_abs: assert property (p_abs) else $error("absolute jump wrong");

  property p_long;
    flow_ok && i_flow.kind == dam_pkg::F_LONG |=> o_pc == $past(i_flow.target);
  endproperty
  a_long: assert property (p_long) else $error("long jump wrong");

  property p_rel;
    flow_ok && i_flow.kind == dam_pkg::F_REL && i_flow.offset == 7'h20 |=>
      o_pc == 15'($past(o_pc) + 15'h0020);
  endproperty
  a_rel: assert property (p_rel) else $error("relative jump wrong");

  property p_ind_jump;
    flow_ok && i_flow.kind == dam_pkg::F_IND |=>
      o_prog_rd && o_flow_busy ##1 o_pc[7:0] == $past(i_prog_data) && !o_flow_busy;
  endproperty
  a_ind_jump: assert property (p_ind_jump) else $error("indirect jump wrong");

  property p_imm;
    req_ok && i_req.mode == dam_pkg::M_IMM |-> ##2 o_rd.data == $past(i_req.imm, 2);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate operand wrong");

  property p_prog;
    req_ok && i_req.mode == dam_pkg::M_PROG |=>
      o_prog_rd && o_prog_addr == {$past(o_pc[14:8]), $past(i_req.acc)};
  endproperty
  a_prog: assert property (p_prog) else $error("program load address wrong");

  property p_per;
    req_ok && i_req.mode == dam_pkg::M_DIRECT && i_req.addr == 8'hC8 |=>
      o_per.rd && o_per.addr == 8'hC8;
  endproperty
  a_per: assert property (p_per) else $error("peripheral decode wrong");

  property p_prog_clash;
    i_req.valid && i_req.mode == dam_pkg::M_PROG && flow_ok &&
    i_flow.kind == dam_pkg::F_IND |-> ##2 !o_rd.valid;
  endproperty
  a_prog_clash: assert property (p_prog_clash) else $error("port clash answered");

  property p_ro_wr;
    wr_en && region == dam_pkg::R_PERIPH && f_is_ro(eff_addr) |=> o_per.rd && !o_per.wr;
  endproperty
  a_ro_wr: assert property (p_ro_wr) else $error("read-only pins strobed");

  property p_post_inc;
    post_en && i_req.post == dam_pkg::P_INC && !i_req.ptr_sel |=>
      ram_mem[f_idx(dam_pkg::ADDR_FIRST_PTR)] == 8'($past(ptr_val) + 8'h01);
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("pointer not incremented");

  c_clash: cover property (i_req.valid && i_req.mode == dam_pkg::M_PROG && flow_ok &&
                           i_flow.kind == dam_pkg::F_IND);
  c_post: cover property (post_en ##1 req_ok);
  c_wd: cover property (wr_en && region == dam_pkg::R_WDOG ##1 wd_lock_ff);
  c_ind: cover property (flow_ok && i_flow.kind == dam_pkg::F_IND ##2 o_rd.valid);
endmodule : dam_core

// ### tb/dam_mem_model.sv
// Purpose: Peripheral and program memory model facing the data map block
// Assumes: Read data is needed combinationally while a read strobe is high
// Notes: Outside a strobe both data buses carry a pattern that changes every cycle
module dam_mem_model (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire dam_pkg::dam_per_t i_per,
  input wire logic i_prog_rd,
  input wire logic [14:0] i_prog_addr,
  output logic [7:0] o_per_rdata,
  output logic [7:0] o_prog_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] churn_ff;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      churn_ff <= 8'h00;
    end else begin
      churn_ff <= churn_ff + 8'h27;
    end
  end
  // Data is a known function of the address so the bench can predict it
  assign o_per_rdata = i_per.rd ? (i_per.addr ^ 8'h3C) : churn_ff;
  assign o_prog_data = i_prog_rd ? (i_prog_addr[7:0] ^ 8'hA5) : ~churn_ff;
endmodule : dam_mem_model

// ### tb/tb_data_map_and_address_modes.sv
// Purpose: Self-checking bench for the data map and address mode block
// Assumes: Accesses answer two cycles after the taking edge
// Notes: Runs the small variant first, then resets into the large variant
module tb_data_map_and_address_modes;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk;
  logic i_rst;
  logic i_large_mem;
  dam_pkg::dam_req_t req;
  dam_pkg::dam_flow_t flow;
  logic [7:0] per_rdata;
  logic [7:0] prog_data;
  dam_pkg::dam_rd_t rd;
  dam_pkg::dam_per_t per;
  logic prog_rd;
  logic [14:0] prog_addr;
  logic [14:0] pc;
  logic flow_busy;
  logic wdog_arm;
  int err_total;
  int total_checks;
  int cycles;
  dam_pkg::dam_rd_t got;
  dam_pkg::dam_per_t got_per;
  logic [14:0] got_paddr;
  logic busy_seen;
  logic got_prog_rd;
  logic [7:0] per_list [21] = '{8'hC8, 8'hC9, 8'hCA, 8'hCC, 8'hCE, 8'hCF, 8'hD0, 8'hD1, 8'hD2,
    8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'hDC, 8'hE9, 8'hEA, 8'hEB, 8'hEC, 8'hED, 8'hEE, 8'hEF};
  logic [7:0] undef_list [12] = '{8'h80, 8'hBF, 8'hC0, 8'hC7, 8'hCB, 8'hD3, 8'hD8, 8'hDB,
    8'hDD, 8'hDF, 8'hE0, 8'hE8};

  dam_core dam_core_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_large_mem(i_large_mem),
    .i_req(req), .i_flow(flow), .i_per_rdata(per_rdata), .i_prog_data(prog_data),
    .o_rd(rd), .o_per(per), .o_prog_rd(prog_rd), .o_prog_addr(prog_addr), .o_pc(pc),
    .o_flow_busy(flow_busy), .o_wdog_arm(wdog_arm));
  dam_mem_model dam_mem_model_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_per(per),
    .i_prog_rd(prog_rd), .i_prog_addr(prog_addr), .o_per_rdata(per_rdata),
    .o_prog_data(prog_data));

  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  task automatic wrap_up();
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      wrap_up();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string what);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask : chk

  // ****************************************
  // Access and flow cycles
  // ****************************************
  task automatic acc(input logic w, input dam_pkg::dam_mode_t m, input logic ps,
    input dam_pkg::dam_post_t po, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    req = '{1'b1, w, m, ps, po, a, d, d, d};
    @(negedge i_mclk);
    req.valid = 1'b0;
    got_per = per;
    got_paddr = prog_addr;
    got_prog_rd = prog_rd;
    @(negedge i_mclk);
    got = rd;
    chk(16'(got.valid), 16'h1, "answer strobe");
  endtask : acc

  task automatic rd_chk(input logic [7:0] a, input dam_pkg::dam_region_t r,
    input logic [7:0] d);
    acc(1'b0, dam_pkg::M_DIRECT, 1'b0, dam_pkg::P_NONE, a, 8'h00);
    chk(16'(got.region), 16'(r), "region");
    chk(16'(got.data), 16'(d), "read data");
  endtask : rd_chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, dam_pkg::M_DIRECT, 1'b0, dam_pkg::P_NONE, a, d);
  endtask : wr

  task automatic fl(input dam_pkg::dam_kind_t k, input logic [6:0] o, input logic [14:0] t,
    input logic [7:0] a, input logic [14:0] e);
    @(negedge i_mclk);
    flow = '{1'b1, k, o, t, a};
    @(negedge i_mclk);
    flow.valid = 1'b0;
    busy_seen = flow_busy;
    got_paddr = prog_addr;
    @(negedge i_mclk);
    chk(16'(pc), 16'(e), "program counter");
  endtask : fl

  initial begin
    i_rst = 1'b1;
    i_large_mem = 1'b0;
    req = '0;
    flow = '0;
    err_total = 0;
    total_checks = 0;
    cycles = 0;
    repeat (2) @(negedge i_mclk);
    i_rst = 1'b0;
    chk(16'(pc), 16'h0000, "pc after reset");
    chk(16'(wdog_arm), 16'h0000, "arm after reset");
    wr(8'h2F, 8'h5A);
    rd_chk(8'h2F, dam_pkg::R_RAM, 8'h5A);
    wr(8'h30, 8'h12);
    rd_chk(8'h30, dam_pkg::R_ONES, 8'hFF);
    for (int i = 0; i < 12; i++) begin
      rd_chk(undef_list[i], dam_pkg::R_UNDEF, dam_pkg::UNDEF_DATA);
    end
    for (int i = 0; i < 21; i++) begin
      rd_chk(per_list[i], dam_pkg::R_PERIPH, per_list[i] ^ 8'h3C);
      chk(16'(got_per.rd), 16'h1, "periph read");
      chk(16'(got_per.addr), 16'(per_list[i]), "periph addr");
    end
    wr(8'hD2, 8'h77);
    chk(16'(got_per.wr), 16'h0, "pins write");
    wr(8'hD0, 8'h77);
    chk(16'({got_per.wr, got_per.wdata}), 16'h0177, "port write");
    wr(8'hCD, 8'h01);
    chk(16'(wdog_arm), 16'h1, "arm first write");
    wr(8'hCD, 8'h00);
    chk(16'(wdog_arm), 16'h1, "arm locked");
    rd_chk(8'hCD, dam_pkg::R_WDOG, 8'h01);
    wr(8'hFE, 8'h10);
    wr(8'hFC, 8'h20);
    wr(8'h1F, 8'h66);
    acc(1'b1, dam_pkg::M_IND_POST, 1'b0, dam_pkg::P_INC, 8'h00, 8'h44);
    acc(1'b1, dam_pkg::M_IND_POST, 1'b1, dam_pkg::P_DEC, 8'h00, 8'h55);
    rd_chk(8'hFE, dam_pkg::R_RAM, 8'h11);
    rd_chk(8'hFC, dam_pkg::R_RAM, 8'h1F);
    rd_chk(8'h10, dam_pkg::R_RAM, 8'h44);
    rd_chk(8'h20, dam_pkg::R_RAM, 8'h55);
    acc(1'b0, dam_pkg::M_IND, 1'b1, dam_pkg::P_NONE, 8'h00, 8'h00);
    chk(16'(got.data), 16'h0066, "indirect read");
    rd_chk(8'hFC, dam_pkg::R_RAM, 8'h1F);
    acc(1'b0, dam_pkg::M_IMM, 1'b0, dam_pkg::P_NONE, 8'h00, 8'hC3);
    chk(16'({got.region, got.data}), 16'({dam_pkg::R_IMM, 8'hC3}), "immediate");
    acc(1'b1, dam_pkg::M_SHORT, 1'b0, dam_pkg::P_NONE, 8'h00, 8'hFB);
    chk(16'(got.data), 16'h0011, "short old");
    rd_chk(8'hFE, dam_pkg::R_RAM, 8'h0B);
    wr(8'hF3, 8'h9A);
    rd_chk(8'hF3, dam_pkg::R_RAM, 8'h9A);
    fl(dam_pkg::F_LONG, 7'h00, 15'h0FF0, 8'h00, 15'h0FF0);
    fl(dam_pkg::F_REL, 7'h20, 15'h0000, 8'h00, 15'h1010);
    fl(dam_pkg::F_REL, 7'h61, 15'h0000, 8'h00, 15'h0FF1);
    fl(dam_pkg::F_REL, 7'h01, 15'h0000, 8'h00, 15'h0FF2);
    fl(dam_pkg::F_INC, 7'h00, 15'h0000, 8'h00, 15'h0FF3);
    fl(dam_pkg::F_LONG, 7'h00, 15'h7ABC, 8'h00, 15'h7ABC);
    fl(dam_pkg::F_ABS, 7'h00, 15'h0123, 8'h00, 15'h7123);
    acc(1'b0, dam_pkg::M_PROG, 1'b0, dam_pkg::P_NONE, 8'h00, 8'h34);
    chk(16'(got_prog_rd), 16'h1, "prog strobe");
    chk(16'(got_paddr), 16'h7134, "prog addr");
    chk(16'({got.region, got.data}), 16'({dam_pkg::R_PROG, 8'h91}), "prog data");
    fl(dam_pkg::F_IND, 7'h00, 15'h0000, 8'h56, 15'h71F3);
    chk(16'({busy_seen, got_paddr}), 16'hF156, "indirect fetch");
    @(negedge i_mclk);
    req = '{1'b1, 1'b0, dam_pkg::M_PROG, 1'b0, dam_pkg::P_NONE, 8'h00, 8'h00, 8'h0C, 8'h00};
    flow = '{1'b1, dam_pkg::F_IND, 7'h00, 15'h0000, 8'h0C};
    @(negedge i_mclk);
    req.valid = 1'b0;
    flow.valid = 1'b0;
    @(negedge i_mclk);
    chk(16'({rd.valid, pc}), 16'h71A9, "program port clash");
    i_rst = 1'b1;
    i_large_mem = 1'b1;
    repeat (2) @(negedge i_mclk);
    i_rst = 1'b0;
    wr(8'hCD, 8'h00);
    wr(8'hCD, 8'h01);
    chk(16'(wdog_arm), 16'h0, "arm relocked");
    wr(8'h6F, 8'hA5);
    rd_chk(8'h6F, dam_pkg::R_RAM, 8'hA5);
    rd_chk(8'h70, dam_pkg::R_ONES, 8'hFF);
    rd_chk(8'h7F, dam_pkg::R_ONES, 8'hFF);
    wrap_up();
  end
endmodule : tb_data_map_and_address_modes
